// file: core/bsc_jtag_ctl.sv
// Test interface control register and boundary-scan chain.
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module bsc_jtag_ctl
    import bsc_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Wishbone classic slave.
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [3:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    // Fuse and test access port decode.
    input  wire logic            testIfFuse,
    output logic                 testIfEnable,
    output logic                 forceReset,
    input  wire logic            tck,
    input  wire logic            tdi,
    input  wire logic            captureDr,
    input  wire logic            shiftDr,
    input  wire logic            updateDr,
    input  wire logic            selBoundary,
    input  wire logic            selReset,
    input  wire logic            extestMode,
    output logic                 tdoOut,
    output logic                 tdoOe,
    // Port pins and core port state.
    input  wire logic [NPIN-1:0] padIn,
    output logic      [NPIN-1:0] padOut,
    output logic      [NPIN-1:0] padOe,
    output logic      [NPIN-1:0] pullupOn,
    input  wire logic [NPIN-1:0] portBit,
    input  wire logic [NPIN-1:0] dirBit,
    input  wire logic            pullupDisable,
    // Reset pin observation.
    input  wire logic            rstPin_n,
    input  wire logic            hvProgReset,
    // Clock options.
    input  wire logic [3:0]      clkEnSys,
    input  wire logic [3:0]      clkLineIn,
    output logic      [3:0]      clkEnOut,
    input  wire logic            intCapSel,
    output logic                 intCapOut,
    // Analog comparator boundary.
    input  wire logic            compIdleSys,
    input  wire logic            bandgapEnSys,
    input  wire logic            compOutRaw,
    output logic                 compIdleOut,
    output logic                 bandgapEnOut,
    output logic                 compOutCore
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic regHit(input logic [3:0] adr,
                                    input logic [3:0] off);
        regHit = (adr[3:2] == off[3:2]);
    endfunction : regHit

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]          tapSync;
    logic [NPIN-1:0]     padSync;
    logic [6:0]          obsSync;
    logic                tckS;
    logic                tdiS;
    logic                capS;
    logic                shiftS;
    logic                updS;
    logic                selBsS;
    logic                selRstS;
    logic                extestEff;
    logic                tckRise;
    logic                tckFall;
    logic                tckPrev_q;
    logic [CHAIN_LEN-1:0] chain_q;
    logic [CHAIN_LEN-1:0] chain_d;
    logic [CHAIN_LEN-1:0] upd_q;
    logic [CHAIN_LEN-1:0] upd_d;
    logic [CHAIN_LEN-1:0] capVec;
    logic                rstReg_q;
    logic                rstReg_d;
    logic                tdo_q;
    logic                tdo_d;
    logic                tdoOe_q;
    logic                tdoOe_d;
    logic [NPIN-1:0]     capData;
    logic [NPIN-1:0]     capCtrl;
    logic [NPIN-1:0]     capPull;

    bsc_sync #(.W(8)) u_tapSync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({tck, tdi, captureDr, shiftDr, updateDr,
                 selBoundary, selReset, extestMode}),
        .q     (tapSync)
    );

    bsc_sync #(.W(NPIN)) u_padSync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (padIn),
        .q     (padSync)
    );

    // The comparator output is analog and arrives with no clock relation.
    bsc_sync #(.W(7)) u_obsSync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({compOutRaw, rstPin_n, hvProgReset, clkLineIn}),
        .q     (obsSync)
    );

    assign {tckS, tdiS, capS, shiftS, updS, selBsS, selRstS} = tapSync[7:1];
    assign tckRise   = tckS && !tckPrev_q;
    assign tckFall   = !tckS && tckPrev_q;
    assign extestEff = tapSync[0] && testIfEnable;

    ////////////////////////////////////////////////////////////////////////
    // Port pin cells.
    generate
        for (genvar i = 0; i < NPIN; i++)
        begin : g_pin
            bsc_pin_cell u_cell (
                .extest        (extestEff),
                .portBit       (portBit[i]),
                .dirBit        (dirBit[i]),
                .pullupDisable (pullupDisable),
                .padLevel      (padSync[i]),
                .updData       (upd_q[3*i+2]),
                .updCtrl       (upd_q[3*i+1]),
                .updPull       (upd_q[3*i]),
                .padOut        (padOut[i]),
                .padOe         (padOe[i]),
                .pullupOn      (pullupOn[i]),
                .capData       (capData[i]),
                .capCtrl       (capCtrl[i]),
                .capPull       (capPull[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Clock enables and comparator inputs take the update stage in extest.
    always_comb
    begin
        clkEnOut     = extestEff ? upd_q[BASE_CEN +: 4] : clkEnSys;
        compIdleOut  = extestEff ? upd_q[BASE_CMP] : compIdleSys;
        bandgapEnOut = extestEff ? upd_q[BASE_CMP+2] : bandgapEnSys;
        compOutCore  = extestEff ? upd_q[BASE_CMP+1] : obsSync[6];
    end

    // Capacitor selection bypasses the chain entirely.
    assign intCapOut = intCapSel;

    always_comb
    begin
        capVec = '0;
        for (int i = 0; i < NPIN; i++)
        begin
            capVec[3*i]   = capPull[i];
            capVec[3*i+1] = capCtrl[i];
            capVec[3*i+2] = capData[i];
        end
        capVec[BASE_RST]   = !obsSync[5];
        capVec[BASE_RST+1] = obsSync[4];
        capVec[BASE_CEN +: 4] = clkEnOut;
        // A clock line of an option that is not enabled reads zero.
        capVec[BASE_CLN +: 4] = obsSync[3:0] & clkEnOut;
        capVec[BASE_CMP]   = compIdleOut;
        capVec[BASE_CMP+1] = obsSync[6] && !compIdleOut;
        capVec[BASE_CMP+2] = bandgapEnOut;
    end

    ////////////////////////////////////////////////////////////////////////
    // Chain, update stage and reset register, stepped on test clock edges.
    always_comb
    begin
        chain_d  = chain_q;
        upd_d    = upd_q;
        rstReg_d = rstReg_q;
        tdo_d    = tdo_q;
        tdoOe_d  = tdoOe_q;
        if (!testIfEnable)
        begin
            rstReg_d = 1'h0;
            tdoOe_d  = 1'h0;
        end
        else
        begin
            if (tckRise && selBsS && capS)
                chain_d = capVec;
            else if (tckRise && selBsS && shiftS)
                chain_d = {tdiS, chain_q[CHAIN_LEN-1:1]};
            if (tckRise && selBsS && updS)
                upd_d = chain_q;
            if (tckRise && selRstS && shiftS)
                rstReg_d = tdiS;
            if (tckFall)
            begin
                tdo_d   = selRstS ? rstReg_q : (selBsS && chain_q[0]);
                tdoOe_d = shiftS;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tckPrev_q <= 1'h0;
            chain_q   <= '0;
            upd_q     <= '0;
            rstReg_q  <= 1'h0;
            tdo_q     <= 1'h0;
            tdoOe_q   <= 1'h0;
        end
        else
        begin
            tckPrev_q <= tckS;
            chain_q   <= chain_d;
            upd_q     <= upd_d;
            rstReg_q  <= rstReg_d;
            tdo_q     <= tdo_d;
            tdoOe_q   <= tdoOe_d;
        end
    end

    assign tdoOut = tdo_q;
    assign tdoOe  = tdoOe_q;
    // The reset request follows the register without a latch.
    assign forceReset = rstReg_q && testIfEnable;

    ////////////////////////////////////////////////////////////////////////
    // Register bus and control register.
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic        testIfDisable_q;
    logic        testIfDisable_d;
    logic        testResetFlag_q;
    logic        testResetFlag_d;
    logic [2:0]  armCnt_q;
    logic [2:0]  armCnt_d;
    logic        armVal_q;
    logic        armVal_d;
    logic        writeMcs;

    assign writeMcs = ack_q && wb_cyc_i && wb_stb_i && wb_we_i
                      && wb_sel_i[0] && regHit(wb_adr_i, REG_MCS_OFF);
    assign testIfEnable = testIfFuse && !testIfDisable_q;

    always_comb
    begin
        ack_d           = wb_cyc_i && wb_stb_i && !ack_q;
        rdData_d        = DATA_ZERO;
        testIfDisable_d = testIfDisable_q;
        testResetFlag_d = testResetFlag_q;
        armCnt_d        = (armCnt_q != 3'h0) ? armCnt_q - 3'h1 : 3'h0;
        armVal_d        = armVal_q;
        if (ack_d && regHit(wb_adr_i, REG_MCS_OFF))
        begin
            rdData_d[MCS_DISABLE_BIT] = testIfDisable_q;
            rdData_d[MCS_FLAG_BIT]    = testResetFlag_q;
        end
        else if (ack_d && regHit(wb_adr_i, REG_STAT_OFF))
        begin
            rdData_d[STAT_EN_BIT]    = testIfEnable;
            rdData_d[STAT_FORCE_BIT] = forceReset;
            rdData_d[STAT_ARMED_BIT] = (armCnt_q != 3'h0);
        end
        if (writeMcs)
        begin
            // A second equal write inside the window commits the value.
            if (armCnt_q != 3'h0 && armVal_q == wb_dat_i[MCS_DISABLE_BIT])
            begin
                testIfDisable_d = wb_dat_i[MCS_DISABLE_BIT];
                armCnt_d        = 3'h0;
            end
            else
            begin
                armVal_d = wb_dat_i[MCS_DISABLE_BIT];
                armCnt_d = TIMED_WINDOW;
            end
            if (!wb_dat_i[MCS_FLAG_BIT])
                testResetFlag_d = 1'h0;
        end
        // Setting wins over a clear in the same cycle.
        if (forceReset)
            testResetFlag_d = 1'h1;
    end

    // The synchronous reset stands for the power-on reset here.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_q           <= 1'h0;
            rdData_q        <= DATA_ZERO;
            testIfDisable_q <= DISABLE_RESET;
            testResetFlag_q <= 1'h0;
            armCnt_q        <= 3'h0;
            armVal_q        <= 1'h0;
        end
        else
        begin
            ack_q           <= ack_d;
            rdData_q        <= rdData_d;
            testIfDisable_q <= testIfDisable_d;
            testResetFlag_q <= testResetFlag_d;
            armCnt_q        <= armCnt_d;
            armVal_q        <= armVal_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_disable_freezes_chain: assert property (
        !testIfEnable && !$past(testIfEnable) |=> $stable(chain_q))
        else $error("chain moved while test interface disabled");

    a_single_write_holds: assert property (
        writeMcs && armCnt_q == 3'h0 |=> $stable(testIfDisable_q))
        else $error("disable bit changed on a single write");

    a_double_write_sets: assert property (
        writeMcs && armCnt_q != 3'h0
        && armVal_q == wb_dat_i[MCS_DISABLE_BIT]
        |=> testIfDisable_q == $past(wb_dat_i[MCS_DISABLE_BIT]))
        else $error("second equal write did not commit");

    a_window_closes: assert property (
        armCnt_q != 3'h0 && !writeMcs
        |=> armCnt_q == $past(armCnt_q) - 3'h1 && armCnt_q < TIMED_WINDOW)
        else $error("timed window longer than four cycles");

    a_flag_on_force: assert property (
        forceReset |=> testResetFlag_q)
        else $error("test reset flag not set by forced reset");

    a_flag_clear_zero: assert property (
        writeMcs && !wb_dat_i[MCS_FLAG_BIT] && !forceReset
        |=> !testResetFlag_q)
        else $error("writing zero did not clear the flag");

    a_clock_unused_zero: assert property (
        tckRise && selBsS && capS && testIfEnable && !clkEnOut[CLK_EXT]
        |=> !chain_q[BASE_CLN+CLK_EXT])
        else $error("unused clock line captured as one");

    a_comp_idle_zero: assert property (
        tckRise && selBsS && capS && testIfEnable && compIdleOut
        |=> !chain_q[BASE_CMP+1])
        else $error("idle comparator output captured as one");

    a_pin_raw_capture: assert property (
        tckRise && selBsS && capS && testIfEnable
        |=> chain_q[2] == $past(padSync[0]))
        else $error("pin data stage did not capture pad level");

    a_ack_single_pulse: assert property (
        ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");

    c_disable_commit: cover property (
        writeMcs && armCnt_q != 3'h0
        && armVal_q == wb_dat_i[MCS_DISABLE_BIT]);
    c_force_reset: cover property (forceReset);
    c_chain_capture: cover property (tckRise && selBsS && capS);
    c_chain_update: cover property (tckRise && selBsS && updS && extestEff);
endmodule : bsc_jtag_ctl

// file: pkg/bsc_pkg.sv
// Constants and register map of the boundary-scan cells and test control.
package bsc_pkg;
    localparam int NPIN     = 31;
    localparam int BASE_RST = 3 * NPIN;
    localparam int BASE_CEN = BASE_RST + 2;
    localparam int BASE_CLN = BASE_CEN + 4;
    localparam int BASE_CMP = BASE_CLN + 4;
    localparam int CHAIN_LEN = BASE_CMP + 3;

    // Order of clock pairs in the enable and line groups.
    localparam int CLK_EXT   = 0;
    localparam int CLK_XTAL  = 1;
    localparam int CLK_LOWF  = 2;
    localparam int CLK_TIMER = 3;

    // Register byte offsets on the bus.
    localparam logic [3:0] REG_MCS_OFF  = 4'h0;
    localparam logic [3:0] REG_STAT_OFF = 4'h4;

    // Bit positions in mcu_control_status and the status register.
    localparam int MCS_DISABLE_BIT = 7;
    localparam int MCS_FLAG_BIT    = 4;
    localparam int STAT_EN_BIT     = 0;
    localparam int STAT_FORCE_BIT  = 1;
    localparam int STAT_ARMED_BIT  = 2;

    // Window for the second write of the timed sequence, in cycles.
    localparam logic [2:0] TIMED_WINDOW = 3'h4;

    localparam logic       DISABLE_RESET = 1'h0;
    localparam logic [31:0] DATA_ZERO    = 32'h0;
endpackage : bsc_pkg

// file: core/bsc_sync.sv
// Two flip-flop synchroniser for levels from outside the clock domain.
`timescale 1ns/1ps
module bsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stage1_q <= '0;
            stage2_q <= '0;
        end
        else
        begin
            stage1_q <= d;
            stage2_q <= stage1_q;
        end
    end

    assign q = stage2_q;
endmodule : bsc_sync

// file: core/bsc_pin_cell.sv
// Scan view of one bidirectional port pin with its pull-up.
`timescale 1ns/1ps
module bsc_pin_cell (
    input  wire logic extest,
    input  wire logic portBit,
    input  wire logic dirBit,
    input  wire logic pullupDisable,
    input  wire logic padLevel,
    input  wire logic updData,
    input  wire logic updCtrl,
    input  wire logic updPull,
    output logic      padOut,
    output logic      padOe,
    output logic      pullupOn,
    output logic      capData,
    output logic      capCtrl,
    output logic      capPull
);
    logic pullExpr;

    // Outside extest, pull-up is on only for an input pin whose port bit is one.
    assign pullExpr = !pullupDisable && !dirBit && portBit;

    always_comb
    begin
        if (extest)
        begin
            padOut   = updData;
            padOe    = updCtrl;
            pullupOn = updPull;
        end
        else
        begin
            padOut   = portBit;
            padOe    = dirBit;
            pullupOn = pullExpr;
        end
    end

    // The data stage captures the pad itself, never the input register.
    assign capData = padLevel;
    assign capCtrl = dirBit;
    assign capPull = pullExpr;
endmodule : bsc_pin_cell

// file: testbench/bsc_tap_model.sv
// Behavioural boundary-scan test controller running its own link clock.
`timescale 1ns/1ps
module bsc_tap_model
    import bsc_pkg::*;
(
    output logic      tck,
    output logic      tdi,
    output logic      captureDr,
    output logic      shiftDr,
    output logic      updateDr,
    output logic      selBoundary,
    output logic      selReset,
    output logic      extestMode,
    input  wire logic tdoOut
);
    // Half of the 800 ns link clock period.
    localparam time HALF = 400ns;
    // Offset so that link edges never coincide with a system clock edge.
    localparam time SKEW = 20ns;

    initial
    begin
        {tck, tdi, captureDr, shiftDr, updateDr} = 5'h0;
        {selBoundary, selReset, extestMode} = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // The link clock idles low between frames; controls change on its fall.
    task automatic pulse;
        #HALF tck = 1'b1;
        #HALF tck = 1'b0;
    endtask : pulse

    // Comparator cells are shifted and updated along with the pin and clock cells.
    task automatic scan(input logic ext, input logic [CHAIN_LEN-1:0] din,
                        output logic [CHAIN_LEN-1:0] dout);
        #SKEW;
        extestMode = ext;
        {selBoundary, captureDr} = 2'h3;
        pulse();
        {captureDr, shiftDr} = 2'h1;
        for (int i = 0; i < CHAIN_LEN; i++)
        begin
            tdi = din[i];
            #HALF dout[i] = tdoOut;
            tck = 1'b1;
            #HALF tck = 1'b0;
        end
        {shiftDr, updateDr} = 2'h1;
        pulse();
        {updateDr, selBoundary} = 2'h0;
        // A released data line shows the inverse, not a stale value.
        tdi = ~tdi;
    endtask : scan

    task automatic load_reset(input logic v);
        #SKEW;
        {selReset, shiftDr, tdi} = {2'h3, v};
        pulse();
        {selReset, shiftDr, tdi} = {2'h0, ~v};
    endtask : load_reset
endmodule : bsc_tap_model

// file: testbench/bsc_jtag_ctl_test.sv
// Self-checking bench for the test control register and scan chain.
`timescale 1ns/1ps
module bsc_jtag_ctl_test
    import bsc_pkg::*;
;
    // Row fields: port, direction, pull-up off | out, enable, pull-up.
    localparam logic [5:0] ROWS [8] = '{6'h00, 6'h25, 6'h2c, 6'h36,
                                        6'h12, 6'h08, 6'h3e, 6'h1a};
    localparam int         LIMIT    = 10000;
    logic                  clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [3:0]            wb_adr_i, wb_sel_i, clkEnSys, clkLineIn, clkEnOut;
    logic [31:0]           wb_dat_i, wb_dat_o, rdData;
    logic                  wb_ack_o, testIfFuse, testIfEnable, forceReset;
    logic                  tck, tdi, captureDr, shiftDr, updateDr;
    logic                  selBoundary, selReset, extestMode, tdoOut, tdoOe;
    logic [NPIN-1:0]       padIn, padOut, padOe, pullupOn, portBit, dirBit;
    logic [NPIN-1:0]       expOut, expOe, expPull;
    logic                  pullupDisable, rstPin_n, hvProgReset;
    logic                  intCapSel, intCapOut, compIdleSys, bandgapEnSys;
    logic                  compOutRaw, compIdleOut, bandgapEnOut, compOutCore;
    logic [CHAIN_LEN-1:0]  din, gotChain, expChain;
    int                    numErrors, numChecks, cycleCount;

    bsc_jtag_ctl i_dut (
        .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .testIfFuse, .testIfEnable,
        .forceReset, .tck, .tdi, .captureDr, .shiftDr, .updateDr,
        .selBoundary, .selReset, .extestMode, .tdoOut, .tdoOe, .padIn,
        .padOut, .padOe, .pullupOn, .portBit, .dirBit, .pullupDisable,
        .rstPin_n, .hvProgReset, .clkEnSys, .clkLineIn, .clkEnOut,
        .intCapSel, .intCapOut, .compIdleSys, .bandgapEnSys, .compOutRaw,
        .compIdleOut, .bandgapEnOut, .compOutCore
    );

    bsc_tap_model i_tap (
        .tck, .tdi, .captureDr, .shiftDr, .updateDr, .selBoundary,
        .selReset, .extestMode, .tdoOut
    );

    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("Checks %0d, errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    always @(posedge clk)
    begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == LIMIT)
        begin
            numErrors++;
            stop_test();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_chain(input logic [CHAIN_LEN-1:0] got,
                             input logic [CHAIN_LEN-1:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_chain

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic wb_xfer(input logic we, input logic [3:0] adr,
                           input logic [31:0] dat);
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        {wb_adr_i, wb_dat_i} <= {adr, dat};
        // Only the bench's cycle limit ends a wait that never sees ack.
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        rdData = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask : wb_xfer

    task automatic wr(input logic [31:0] dat);
        wb_xfer(1'b1, REG_MCS_OFF, dat);
    endtask : wr

    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, DATA_ZERO);
        chk_word(rdData, exp);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h0f, DATA_ZERO};
        {portBit, dirBit, padIn, din} = '0;
        {pullupDisable, hvProgReset, intCapSel, compOutRaw} = 4'h0;
        {clkEnSys, clkLineIn, bandgapEnSys} = 9'h0;
        {testIfFuse, rstPin_n, compIdleSys} = 3'h7;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(REG_MCS_OFF, DATA_ZERO);
        rd_chk(REG_STAT_OFF, 32'h1);
        rd_chk(4'h8, DATA_ZERO);
        foreach (ROWS[r])
        begin
            @(posedge clk);
            {portBit, dirBit} <= {{NPIN{ROWS[r][5]}}, {NPIN{ROWS[r][4]}}};
            {pullupDisable, intCapSel} <= {ROWS[r][3], ROWS[r][5]};
            {clkEnSys, compIdleSys} <= {4'(r), ROWS[r][3]};
            bandgapEnSys <= ROWS[r][4];
            @(negedge clk);
            chk_word(32'(padOut), 32'({NPIN{ROWS[r][2]}}));
            chk_word(32'(padOe), 32'({NPIN{ROWS[r][1]}}));
            chk_word(32'(pullupOn), 32'({NPIN{ROWS[r][0]}}));
            chk_word(32'({clkEnOut, compIdleOut, bandgapEnOut, intCapOut}),
                     32'({4'(r), ROWS[r][3], ROWS[r][4], ROWS[r][5]}));
        end
        @(posedge clk);
        {pullupDisable, compIdleSys, bandgapEnSys} <= 3'h2;
        wr(32'h80);
        idle(8);
        rd_chk(REG_MCS_OFF, DATA_ZERO);
        wr(32'h80);
        wr(32'h80);
        rd_chk(REG_MCS_OFF, 32'h80);
        chk_word(32'(testIfEnable), DATA_ZERO);
        i_tap.load_reset(1'b1);
        idle(4);
        chk_word(32'(forceReset), DATA_ZERO);
        wr(DATA_ZERO);
        idle(3);
        wr(DATA_ZERO);
        rd_chk(REG_MCS_OFF, 32'h80);
        idle(8);
        wr(DATA_ZERO);
        wr(DATA_ZERO);
        rd_chk(REG_MCS_OFF, DATA_ZERO);
        testIfFuse <= 1'b0;
        @(negedge clk);
        chk_word(32'(testIfEnable), DATA_ZERO);
        @(posedge clk);
        testIfFuse <= 1'b1;
        i_tap.load_reset(1'b1);
        idle(4);
        chk_word(32'(forceReset), 32'h1);
        rd_chk(REG_STAT_OFF, 32'h3);
        rd_chk(REG_MCS_OFF, 32'h10);
        i_tap.load_reset(1'b0);
        idle(4);
        wr(32'h10);
        rd_chk(REG_MCS_OFF, 32'h10);
        wr(DATA_ZERO);
        rd_chk(REG_MCS_OFF, DATA_ZERO);
        i_tap.load_reset(1'b1);
        idle(4);
        rst_n <= 1'b0;
        idle(3);
        rst_n <= 1'b1;
        rd_chk(REG_MCS_OFF, DATA_ZERO);
        @(posedge clk);
        {portBit, dirBit} <= {31'h0f0f_0f0f, 31'h3333_3333};
        {padIn, rstPin_n, hvProgReset, compOutRaw} <= {31'h1234_5678, 3'h3};
        {clkEnSys, clkLineIn} <= 8'h1f;
        idle(4);
        chk_word(32'(compOutCore), 32'h1);
        for (int i = 0; i < NPIN; i++)
            expChain[3*i +: 3] = {padIn[i], dirBit[i], ~dirBit[i] & portBit[i]};
        expChain[CHAIN_LEN-1:BASE_RST] = {3'h1, 4'h1, 4'h1, 2'h3};
        i_tap.scan(1'b0, din, gotChain);
        chk_chain(gotChain, expChain);
        for (int i = 0; i < NPIN; i++)
        begin
            din[3*i +: 3] = 3'(i);
            {expOut[i], expOe[i], expPull[i]} = 3'(i);
        end
        din[CHAIN_LEN-1:BASE_CEN] = {3'h1, 4'h0, 4'h4};
        i_tap.scan(1'b1, din, gotChain);
        @(negedge clk);
        chk_word(32'(padOut), 32'(expOut));
        chk_word(32'(padOe), 32'(expOe));
        chk_word(32'(pullupOn), 32'(expPull));
        chk_word(32'({clkEnOut, compIdleOut, bandgapEnOut, compOutCore,
                      tdoOe}), 32'h48);
        stop_test();
    end
endmodule : bsc_jtag_ctl_test
